// [design/spm_regs.vh]
// spm_regs.vh: field positions and timing constants of the serial master port
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

// global control word fields
`define SPM_GCR_MASTER_BIT    0

// format word fields
`define SPM_FMT_PS_LSB        8
`define SPM_FMT_PS_MSB        15
`define SPM_FMT_PHASE_BIT     16
`define SPM_FMT_POL_BIT       17

// delay configuration word fields
`define SPM_DLY_LEAD_LSB      0
`define SPM_DLY_LEAD_MSB      7
`define SPM_DLY_TRAIL_LSB     8
`define SPM_DLY_TRAIL_MSB     15

// fixed cycle offsets added to the programmed delays, and the serial period at prescale zero
`define SPM_LEAD_BASE         10'h002
`define SPM_LEAD_HOLD_EXTRA   10'h001
`define SPM_TRAIL_BASE        10'h001
`define SPM_PERIOD_PS0        9'h002

// timing: clock period, least serial clock period, and its cycle count
`define SPM_CLK_PERIOD_NS     50
`define SPM_SCLK_MIN_NS       25
`define SPM_SCLK_MIN_CYC      (((`SPM_SCLK_MIN_NS + `SPM_CLK_PERIOD_NS - 1) / `SPM_CLK_PERIOD_NS) < 1 ? 1 : \
                               ((`SPM_SCLK_MIN_NS + `SPM_CLK_PERIOD_NS - 1) / `SPM_CLK_PERIOD_NS))

`endif

// [design/spm_master.v]
// spm_master.v: serial peripheral master port with transmit fifo
// Functional notes
// - master starts frames only when enable set
// - format bit 16 selects clock phase
// - format bit 17 selects clock polarity
// - clock period is prescale plus one cycles, two cycles at prescale zero
// - lead and trail delays programmable in register
// - phase 1 lead: half period plus delay+2/+3
// - cs trails last edge by delay+1 cycles in phase 1, delay+1 plus half period in phase 0
// - output bit launched half period before sample
// - input sampled on phase-dependent polarity edge
// - clock levels split the period in halves, the level after the leading edge one cycle longer when odd
`include "spm_regs.vh"

// ----------------------------------------------------------------
// transmit fifo
// ----------------------------------------------------------------
module spm_fifo #(
  parameter W     = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          rstn,
  // fill side
  input  wire          in_valid,
  input  wire [W-1:0]  in_data,
  output reg           in_ready,
  // drain side
  output wire          out_valid,
  output wire [W-1:0]  out_data,
  input  wire          out_ready
);
  localparam [AW:0] FULL_CNT = DEPTH;  // occupancy at which fill side refuses
  reg  [W-1:0] mem [0:DEPTH-1];  // storage, flip-flops
  reg  [AW-1:0] wr_q;            // write index
  reg  [AW-1:0] rd_q;            // read index
  reg  [AW:0]   cnt_q;           // words held
  reg  [AW:0]   cnt_d;
  wire          push;
  wire          pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];

  // next occupancy
  always @*
  begin
    cnt_d = cnt_q;
    if (push & ~pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop & ~push)
      cnt_d = cnt_q - 1'b1;
  end

  // pointers and count; ready registered so full is exact next cycle
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wr_q     <= {AW{1'b0}};
      rd_q     <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end
    else
    begin
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != FULL_CNT);
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  // storage write, one entry per push
  always @(posedge sys_clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end
endmodule

// ----------------------------------------------------------------
// master port top
// ----------------------------------------------------------------
module spm_master #(
  parameter W     = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          rstn,
  // configuration words
  input  wire [31:0]   global_control_reg,
  input  wire [31:0]   format_reg,
  input  wire [31:0]   delay_config_reg,
  input  wire          cs_keep_active,
  // transmit words
  input  wire          tx_valid,
  input  wire [W-1:0]  tx_data,
  output wire          tx_ready,
  // received words
  output reg           rx_valid,
  output reg  [W-1:0]  rx_data,
  output reg           busy,
  // serial pins
  output reg           serial_clock_pin,
  output reg           master_out_line,
  input  wire          master_in_line,
  output reg           cs_n
);
  localparam EW = $clog2(2*W);
  localparam integer  LAST_I    = 2*W-1;           // index of the final serial edge
  localparam [EW-1:0] LAST_EDGE = LAST_I[EW-1:0];
  // states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_LEAD  = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_TRAIL = 3'h3;
  localparam [2:0] ST_GAP   = 3'h4;

  reg  [2:0]   st_q;             // sequencer state
  reg  [9:0]   cnt_q;            // cycle countdown
  reg  [EW-1:0] edge_q;          // serial edge index
  reg  [W-1:0] tx_sh_q;          // outgoing shifter
  reg  [W-1:0] rx_sh_q;          // incoming shifter
  reg          min_s1_q;         // input synchroniser, stage 1
  reg          min_s2_q;         // input synchroniser, stage 2
  wire         f_valid;
  wire [W-1:0] f_data;
  wire         f_pop;

  // field decode
  wire         master_en = global_control_reg[`SPM_GCR_MASTER_BIT];
  wire         cpha      = format_reg[`SPM_FMT_PHASE_BIT];
  wire         cpol      = format_reg[`SPM_FMT_POL_BIT];
  wire [7:0]   prescale_value = format_reg[`SPM_FMT_PS_MSB:`SPM_FMT_PS_LSB];
  wire [7:0]   lead_dly  = delay_config_reg[`SPM_DLY_LEAD_MSB:`SPM_DLY_LEAD_LSB];
  wire [7:0]   trail_dly = delay_config_reg[`SPM_DLY_TRAIL_MSB:`SPM_DLY_TRAIL_LSB];

  // serial period; a prescale of zero still yields two cycles
  wire [8:0]   period = (prescale_value == 8'h00) ? `SPM_PERIOD_PS0 : {1'b0, prescale_value} + 9'h001;
  // two halves; odd periods give the extra cycle to half_b, the level after the leading edge
  wire [9:0]   half_a = {2'b00, period[8:1]};
  wire [9:0]   half_b = {1'b0, period} - half_a;
  // lead: extra cycle with keep-active in phase 0, or phase 1 with polarity 1
  wire         lead_extra = cs_keep_active & (~cpha | cpol);
  wire [9:0]   lead_len = {2'b00, lead_dly} + `SPM_LEAD_BASE
                        + (lead_extra ? `SPM_LEAD_HOLD_EXTRA : 10'h000)
                        + (cpha ? half_a : 10'h000);
  // trail: phase 0 adds half a period before cs releases
  wire [9:0]   trail_len = {2'b00, trail_dly} + `SPM_TRAIL_BASE
                         + (cpha ? 10'h000 : half_a);
  // edge decode: even edges leave the idle level
  wire         leading   = ~edge_q[0];
  wire         do_sample = cpha ? ~leading : leading;
  wire         do_launch = cpha ? leading : (~leading & (edge_q != LAST_EDGE));
  wire         word_next = cs_keep_active & master_en & f_valid;

  // fifo drained only when a word can start
  assign f_pop = f_valid & master_en & ((st_q == ST_IDLE) | ((st_q == ST_TRAIL) & (cnt_q == 10'h000)
                 & cs_keep_active));

  spm_fifo #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_pop)
  );

  // two-stage synchroniser for the slave data pin
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      min_s1_q <= 1'b0;
      min_s2_q <= 1'b0;
    end
    else
    begin
      min_s1_q <= master_in_line;
      min_s2_q <= min_s1_q;
    end
  end

  // sequencer: lead, shift edges, trail, gap
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      st_q             <= ST_IDLE;
      cnt_q            <= 10'h000;
      edge_q           <= {EW{1'b0}};
      tx_sh_q          <= {W{1'b0}};
      rx_sh_q          <= {W{1'b0}};
      rx_valid         <= 1'b0;
      rx_data          <= {W{1'b0}};
      busy             <= 1'b0;
      serial_clock_pin <= 1'b0;
      master_out_line  <= 1'b0;
      cs_n             <= 1'b1;
    end
    else
    begin
      rx_valid <= 1'b0;
      busy     <= (st_q != ST_IDLE);
      case (st_q)
        ST_IDLE:
        begin
          // pins idle: clock at polarity level, cs inactive
          serial_clock_pin <= cpol;
          cs_n             <= 1'b1;
          if (f_pop)
          begin
            cs_n   <= 1'b0;
            st_q   <= ST_LEAD;
            cnt_q  <= lead_len - 10'h002;
            edge_q <= {EW{1'b0}};
            // phase 0 presents the first bit before the first edge
            if (!cpha)
            begin
              master_out_line <= f_data[W-1];
              tx_sh_q         <= {f_data[W-2:0], 1'b0};
            end
            else
              tx_sh_q <= f_data;
          end
        end
        ST_LEAD:
        begin
          // countdown ends one cycle early; the shift state makes the edge
          if (cnt_q == 10'h000)
            st_q <= ST_SHIFT;
          else
            cnt_q <= cnt_q - 10'h001;
        end
        ST_SHIFT:
        begin
          if (cnt_q == 10'h000)
          begin
            serial_clock_pin <= ~serial_clock_pin;
            if (do_sample)
              rx_sh_q <= {rx_sh_q[W-2:0], min_s2_q};
            if (do_launch)
            begin
              master_out_line <= tx_sh_q[W-1];
              tx_sh_q         <= {tx_sh_q[W-2:0], 1'b0};
            end
            if (edge_q == LAST_EDGE)
            begin
              st_q  <= ST_TRAIL;
              cnt_q <= trail_len - 10'h001;
            end
            else
            begin
              edge_q <= edge_q + 1'b1;
              cnt_q  <= (leading ? half_b : half_a) - 10'h001;
            end
          end
          else
            cnt_q <= cnt_q - 10'h001;
        end
        ST_TRAIL:
        begin
          if (cnt_q == 10'h000)
          begin
            rx_valid <= 1'b1;
            rx_data  <= rx_sh_q;
            if (word_next)
            begin
              // cs stays active into the next word
              st_q   <= ST_LEAD;
              cnt_q  <= lead_len - 10'h002;
              edge_q <= {EW{1'b0}};
              if (!cpha)
              begin
                master_out_line <= f_data[W-1];
                tx_sh_q         <= {f_data[W-2:0], 1'b0};
              end
              else
                tx_sh_q <= f_data;
            end
            else
            begin
              cs_n  <= 1'b1;
              st_q  <= ST_GAP;
              cnt_q <= {1'b0, period} - 10'h001;
            end
          end
          else
            cnt_q <= cnt_q - 10'h001;
        end
        ST_GAP:
        begin
          // one serial period plus one idle cycle of cs inactive between words
          if (cnt_q == 10'h000)
            st_q <= ST_IDLE;
          else
            cnt_q <= cnt_q - 10'h001;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// [verif/spm_master_props.sv]
// spm_master_props.sv: port timing checker of the serial master
module spm_master_props #(
  parameter W = 16
) (
  // clock and reset
  input logic         sys_clk,
  input logic         rstn,
  // configuration
  input logic [31:0]  global_control_reg,
  input logic [31:0]  format_reg,
  input logic [31:0]  delay_config_reg,
  input logic         cs_keep_active,
  // word streams
  input logic         tx_valid,
  input logic [W-1:0] tx_data,
  input logic         tx_ready,
  input logic         rx_valid,
  input logic [W-1:0] rx_data,
  input logic         busy,
  // serial pins
  input logic         serial_clock_pin,
  input logic         master_out_line,
  input logic         master_in_line,
  input logic         cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ------------
  // figures
  // ------------
  wire       pol = format_reg[17];
  wire       ph  = format_reg[16];
  wire [9:0] per = (format_reg[15:8] == 8'h00) ? 10'h002 : {2'h0, format_reg[15:8]} + 10'h001;
  wire [9:0] half = per >> 1;  // short half, odd periods give the long half to leading edges
  wire [9:0] lead_len = {2'h0, delay_config_reg[7:0]} + 10'h002 + {9'h000, cs_keep_active & (~ph | pol)}
                        + (ph ? half : 10'h000);
  wire [9:0] trail_len = {2'h0, delay_config_reg[15:8]} + 10'h001 + (ph ? 10'h000 : half);
  // ------------
  // counters
  // ------------
  logic       sclk_q;   // clock pin one cycle back
  logic [9:0] cnt_q;    // cycles since frame start or last toggle
  logic [4:0] tog_q;    // toggles in the word, wraps after 32
  logic       first_q;  // no toggle yet in this frame
  wire        tog = serial_clock_pin ^ sclk_q;
  // all but sclk_q restart while chip select is high
  always_ff @(posedge sys_clk)
  begin
    sclk_q <= serial_clock_pin;
    if (!rstn || cs_n)
    begin
      cnt_q   <= 10'h000;
      tog_q   <= 5'h00;
      first_q <= 1'b1;
    end
    else
    begin
      cnt_q   <= tog ? 10'h001 : cnt_q + 10'h001;
      tog_q   <= tog_q + {4'h0, tog};
      first_q <= first_q & ~tog;
    end
  end
  idle_level_a: assert property (cs_n && $stable(format_reg) && $past(rstn, 2) |-> serial_clock_pin == pol)
    else $error("clock not at idle level");
  master_only_a: assert property ($fell(cs_n) |-> $past(global_control_reg[0]))
    else $error("frame while not master");
  lead_delay_a: assert property (!cs_n && first_q && tog |-> cnt_q == lead_len)
    else $error("lead delay wrong");
  half_period_a: assert property (!cs_n && !first_q && tog_q != 5'h00 && tog
    |-> cnt_q == ((serial_clock_pin == pol) ? per - half : half))
    else $error("clock half period wrong");
  trail_delay_a: assert property ($rose(cs_n) |-> cnt_q == trail_len)
    else $error("trail delay wrong");
  rx_pulse_a: assert property ($rose(cs_n) |-> rx_valid ##1 !rx_valid)
    else $error("word end pulse wrong");
  cs_release_a: assert property ($rose(cs_n) |=> cs_n)
    else $error("chip select gap too short");
  out_stable_a: assert property (!cs_n && tog && (serial_clock_pin ^ pol ^ ph) |-> $stable(master_out_line))
    else $error("data moved at sample edge");
endmodule

// [verif/spm_slave_model.sv]
// spm_slave_model.sv: behavioural serial slave at the far end of the port
module spm_slave_model (
  // serial pins and mode
  input  logic        serial_clock_pin,
  input  logic        cs_n,
  input  logic        master_out_line,
  input  logic        pol,
  input  logic        ph,
  // words exchanged
  input  logic [15:0] reply_word,
  output logic        master_in_line,
  output logic [15:0] got_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh;  // bits still to send
  int          k;   // launches in this word
  initial master_in_line = 1'b0;
  // drive next bit, reload after a whole word so chained words work
  task automatic launch();
    if (k == 16)
    begin
      sh = reply_word;
      k = 0;
    end
    master_in_line = sh[15];
    sh = {sh[14:0], 1'b0};
    k++;
  endtask
  // phase 0 shows its first bit before any clock edge
  always @(negedge cs_n)
  begin
    sh = reply_word;
    k = 0;
    if (!ph) launch();
  end
  // a released line never keeps a stale bit
  always @(posedge cs_n) master_in_line = ~master_in_line;
  // sample edges capture, launch edges drive
  always @(serial_clock_pin)
    if (!cs_n)
      if (serial_clock_pin ^ pol ^ ph) got_word = {got_word[14:0], master_out_line};
      else launch();
endmodule

// [verif/spm_master_tb_top.sv]
// spm_master_tb_top.sv: self-checking bench of the serial master port
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, g); end end
module spm_master_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rstn, keep, tx_valid, tx_ready, rx_valid, busy, sclk, mosi, miso, cs_n;
  logic [31:0] gcr, fmt, dly;
  logic [15:0] tx_data, rx_data, got, reply;
  int          fails, checked, rises, i;
  spm_master u_spm_master (.sys_clk(sys_clk), .rstn(rstn), .global_control_reg(gcr), .format_reg(fmt),
    .delay_config_reg(dly), .cs_keep_active(keep), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy), .serial_clock_pin(sclk), .master_out_line(mosi),
    .master_in_line(miso), .cs_n(cs_n));
  spm_slave_model u_spm_slave_model (.serial_clock_pin(sclk), .cs_n(cs_n), .master_out_line(mosi),
    .pol(fmt[17]), .ph(fmt[16]), .reply_word(reply), .master_in_line(miso), .got_word(got));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge cs_n) rises++;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait at falling edges for a flag
  task automatic wait_for(input int sel);
    for (i = 0; i < 4000 && ((sel == 0) ? tx_ready : rx_valid) !== 1'b1; i++) @(negedge sys_clk);
    if (i == 4000)
    begin
      fails++;
      report_and_stop();
    end
  endtask
  // push one word; taken at the rising edge where ready is high
  task automatic push(input logic [15:0] w);
    @(negedge sys_clk);
    tx_valid = 1'b1;
    tx_data = w;
    wait_for(0);
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask
  // each word returns the reply, one pulse per word
  task automatic take_rx();
    wait_for(1);
    `CHK("rx_data", reply, rx_data)
    @(negedge sys_clk);
  endtask
  // one configured exchange of n words
  task automatic run(input logic ph, pol, input logic [7:0] ps, ld, tr, input logic kp, input int n,
                     input logic [15:0] rep);
    @(negedge sys_clk);
    fmt = {14'h0000, pol, ph, ps, 8'h00};
    dly = {16'h0000, tr, ld};
    keep = kp;
    reply = rep;
    rises = 0;
    repeat (4) @(negedge sys_clk);
    for (int k = 0; k < n; k++) push(16'ha5c3 + 16'(k));
    repeat (n) take_rx();
    `CHK("slave_word", 16'ha5c3 + 16'(n - 1), got)
    `CHK("cs_rises", kp ? 1 : n, rises)
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge sys_clk);
    `CHK("busy_idle", 1'b0, busy)
    $display("test done phase %0d polarity %0d prescale %0d", ph, pol, ps);
  endtask
  initial
  begin
    rstn = 1'b0;
    gcr = 32'h00000001;
    fmt = 32'h00000000;
    dly = 32'h00000000;
    keep = 1'b0;
    tx_valid = 1'b0;
    tx_data = 16'h0000;
    reply = 16'h0000;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    run(1'b0, 1'b0, 8'h07, 8'h01, 8'h00, 1'b0, 1, 16'h5a3c);
    run(1'b1, 1'b0, 8'h07, 8'h03, 8'h02, 1'b0, 2, 16'hc3a5);
    run(1'b0, 1'b1, 8'h08, 8'h02, 8'h01, 1'b1, 2, 16'h1e87);
    run(1'b1, 1'b1, 8'h09, 8'h01, 8'h05, 1'b1, 2, 16'h96f0);
    run(1'b0, 1'b0, 8'h00, 8'h01, 8'h00, 1'b0, 1, 16'hffff);
    // fill the queue while not master, then drain it
    gcr = 32'h00000000;
    for (int k = 0; k < 16; k++) push(16'(k));
    `CHK("tx_ready_full", 1'b0, tx_ready)
    `CHK("cs_idle", 1'b1, cs_n)
    gcr = 32'h00000001;
    repeat (16) take_rx();
    $display("test done fill and drain");
    report_and_stop();
  end
endmodule
bind spm_master spm_master_props #(.W(W)) u_props (.sys_clk(sys_clk), .rstn(rstn),
  .global_control_reg(global_control_reg), .format_reg(format_reg), .delay_config_reg(delay_config_reg),
  .cs_keep_active(cs_keep_active), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy), .serial_clock_pin(serial_clock_pin),
  .master_out_line(master_out_line), .master_in_line(master_in_line), .cs_n(cs_n));
